// file: fsprx_defines.svh
// Register map, field positions, reset values and timing counts of the serial receiver
`ifndef FSPRX_DEFINES_SVH
`define FSPRX_DEFINES_SVH

// ==========================================================
// Register byte addresses
`define FSPRX_ADDR_MODE 32'hfffe9800
`define FSPRX_ADDR_BAUD 32'hfffe9804
`define FSPRX_ADDR_CTRL 32'hfffe9808
`define FSPRX_ADDR_FLAGS 32'hfffe9810
`define FSPRX_ADDR_DATA 32'hfffe9814
`define FSPRX_ADDR_MASK 32'hfffe9818
`define FSPRX_ADDR_STBY 32'hfffe040c

// ==========================================================
// Field positions
`define FSPRX_MODE_SYNC 7
`define FSPRX_MODE_CHR 6
`define FSPRX_MODE_PE 5
`define FSPRX_MODE_ODD 4
`define FSPRX_MODE_STOP 3
`define FSPRX_MODE_CKS 1:0
`define FSPRX_CTRL_RIE 6
`define FSPRX_CTRL_RE 4
`define FSPRX_CTRL_CKE 1:0
`define FSPRX_CTRL_EXTCK 1
`define FSPRX_STBY_MSTP 4
`define FSPRX_FLAG_ORER 0
`define FSPRX_FLAG_FER 1
`define FSPRX_FLAG_PER 2
`define FSPRX_FLAG_BRK 3
`define FSPRX_FLAG_RDF 4
`define FSPRX_FLAG_CNT 12:8

// ==========================================================
// Reset values
`define FSPRX_MODE_RST 16'h0000
`define FSPRX_BAUD_RST 8'hff
`define FSPRX_CTRL_RST 16'h0000
`define FSPRX_FLAGS_RST 5'h00
`define FSPRX_MASK_RST 5'h1f
`define FSPRX_STBY_RST 8'hff

// ==========================================================
// Timing: 200 MHz * 48 / 125 = 76.8 MHz base; 76.8 MHz / 125 = 16 x 38400
`define FSPRX_FRAC_STEP 8'h30
`define FSPRX_FRAC_MOD 8'h7d
`define FSPRX_PRE_DIV1 6'h00
`define FSPRX_PRE_DIV4 6'h03
`define FSPRX_PRE_DIV16 6'h0f
`define FSPRX_PRE_DIV64 6'h3f
`define FSPRX_OVS_LAST 4'hf
`define FSPRX_MID_LAST 4'h7
`define FSPRX_BITS8_LAST 3'h7
`define FSPRX_BITS7_LAST 3'h6

// ==========================================================
// Receive FIFO
`define FSPRX_FIFO_DEPTH 16
`define FSPRX_FIFO_FULLCNT 5'h10
`define FSPRX_RDF_TRIG 5'h08

`endif

// file: fsprx_fifo.sv
// Sixteen-entry receive character FIFO
`timescale 1ns/1ps
`include "fsprx_defines.svh"
module fsprx_fifo
    import fsprx_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic push,
    input fsprx_char_t wdata,
    input wire logic pop,
    output fsprx_char_t rdata,
    output logic full,
    output logic empty,
    output logic [4:0] count
);
    fsprx_char_t mem [`FSPRX_FIFO_DEPTH];
    logic [3:0] wp;
    logic [3:0] rp;

    wire do_push = push & ~full;
    wire do_pop = pop & ~empty;

    assign full = (count == `FSPRX_FIFO_FULLCNT);
    assign empty = (count == 5'h00);
    assign rdata = mem[rp];

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wp] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wp <= 4'h0;
            rp <= 4'h0;
            count <= 5'h00;
        end else begin
            wp <= wp + 4'(do_push);
            rp <= rp + 4'(do_pop);
            count <= count + 5'(do_push) - 5'(do_pop);
        end
    end
endmodule

// file: fsprx_pkg.sv
// Types shared by the serial receiver modules
package fsprx_pkg;

    typedef enum logic [2:0] {
        FSPRX_IDLE,
        FSPRX_START,
        FSPRX_DATA,
        FSPRX_PARITY,
        FSPRX_STOP
    } fsprx_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic perr;
        logic ferr;
    } fsprx_char_t;

endpackage

// file: fsprx_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module fsprx_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RV = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta <= RV;
            q <= RV;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// file: fsprx_top.sv
// Asynchronous serial receiver with FIFO and APB register file
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "fsprx_defines.svh"

// Summary of operation
// - Mode bit zero selects asynchronous framing
// - Length bit zero gives eight data bits
// - Parity enable zero skips parity bit
// - Stop bit zero means one stop
// - Divisor 124 at clock select zero: 38400
// - Receive interrupt enable gates full and error
// - Receive only while receive enable is one
// - Clock enable zero uses internal baud clock
// - Writing zero to flags clears them all; a flag set in that cycle, and RDF while eight or more wait, stay set
// - Module stop bit must be zero to run
// - Idle high, start low, LSB first, stop high
// - Sixteen-entry receive FIFO buffers characters
// - Detect framing, parity, overrun and break
// - Bit timing from sixteen-times bit clock
module fsprx_top
    import fsprx_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SERIAL_RX_LINE,
    input wire logic SCK_IN,
    output logic IRQ
);
    // ==========================================================
    // Registers
    logic [15:0] serial_frame_mode;
    logic [7:0] baud_divisor;
    logic [15:0] serial_control;
    logic [4:0] serial_flags;
    logic [4:0] irq_mask;
    logic [7:0] standby_control_four;

    // ==========================================================
    // Bus decode
    wire setup = PSEL & ~PENABLE;
    wire access = PSEL & PENABLE;
    wire wr = access & PWRITE;
    wire hit_mode = (PADDR == `FSPRX_ADDR_MODE);
    wire hit_baud = (PADDR == `FSPRX_ADDR_BAUD);
    wire hit_ctrl = (PADDR == `FSPRX_ADDR_CTRL);
    wire hit_flags = (PADDR == `FSPRX_ADDR_FLAGS);
    wire hit_data = (PADDR == `FSPRX_ADDR_DATA);
    wire hit_mask = (PADDR == `FSPRX_ADDR_MASK);
    wire hit_stby = (PADDR == `FSPRX_ADDR_STBY);
    wire hit_any = hit_mode | hit_baud | hit_ctrl | hit_flags | hit_data
        | hit_mask | hit_stby;

    // Zero-wait slave: read data is captured in the setup cycle
    assign PREADY = 1'b1;

    // ==========================================================
    // Configuration fields
    wire sync_mode = serial_frame_mode[`FSPRX_MODE_SYNC];
    wire chr7 = serial_frame_mode[`FSPRX_MODE_CHR];
    wire par_en = serial_frame_mode[`FSPRX_MODE_PE];
    wire par_odd = serial_frame_mode[`FSPRX_MODE_ODD];
    wire [1:0] baud_clock_select = serial_frame_mode[`FSPRX_MODE_CKS];
    wire receive_irq_enable = serial_control[`FSPRX_CTRL_RIE];
    wire re = serial_control[`FSPRX_CTRL_RE];
    wire ext_clk = serial_control[`FSPRX_CTRL_EXTCK];
    wire mstp = standby_control_four[`FSPRX_STBY_MSTP];

    // Receiver runs only in async mode, enabled and out of standby
    wire run = ~mstp & re & ~sync_mode;

    // ==========================================================
    // Pin synchronisers
    logic rx;
    logic sck;

    fsprx_sync #(.W(1), .RV(1'b1)) u_rx_sync (
        .clk(CLK),
        .reset(RESET),
        .d(SERIAL_RX_LINE),
        .q(rx)
    );

    fsprx_sync #(.W(1), .RV(1'b0)) u_sck_sync (
        .clk(CLK),
        .reset(RESET),
        .d(SCK_IN),
        .q(sck)
    );

    // ==========================================================
    // Baud-rate generator
    logic [7:0] frac_acc;
    logic [5:0] pre_cnt;
    logic [7:0] brr_cnt;
    logic sck_prev;

    wire [7:0] frac_sum = frac_acc + `FSPRX_FRAC_STEP;
    wire frac_wrap = (frac_sum >= `FSPRX_FRAC_MOD);
    wire [7:0] next_frac = frac_wrap ? frac_sum - `FSPRX_FRAC_MOD : frac_sum;
    wire [5:0] pre_last = (baud_clock_select == 2'h0) ? `FSPRX_PRE_DIV1 :
                          (baud_clock_select == 2'h1) ? `FSPRX_PRE_DIV4 :
                          (baud_clock_select == 2'h2) ? `FSPRX_PRE_DIV16 : `FSPRX_PRE_DIV64;
    wire pre_en = frac_wrap & (pre_cnt == pre_last);
    wire int_tick = pre_en & (brr_cnt == baud_divisor);
    wire sck_rise = sck & ~sck_prev;
    // External clock is sampled, so it must stay well below CLK / 4
    wire tick = ext_clk ? sck_rise : int_tick;

    always_ff @(posedge CLK) begin
        if (RESET | ~run) begin
            frac_acc <= 8'h00;
            pre_cnt <= 6'h00;
            brr_cnt <= 8'h00;
        end else begin
            frac_acc <= next_frac;
            if (frac_wrap) begin
                pre_cnt <= (pre_cnt == pre_last) ? 6'h00 : pre_cnt + 6'h01;
            end
            if (pre_en) begin
                brr_cnt <= (brr_cnt == baud_divisor) ? 8'h00 : brr_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= sck;
        end
    end

    // ==========================================================
    // Receive state machine
    fsprx_state_t state;
    logic [3:0] ovs;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic par_bit;
    logic rx_prev;

    wire bit_end = tick & (ovs == `FSPRX_OVS_LAST);
    wire [2:0] bits_last = chr7 ? `FSPRX_BITS7_LAST : `FSPRX_BITS8_LAST;
    wire [7:0] rx_data = chr7 ? {1'b0, shreg[7:1]} : shreg;
    wire rx_perr = par_en & ((^rx_data ^ par_bit) != par_odd);
    wire rx_brk = ~rx & (rx_data == 8'h00) & (~par_en | ~par_bit);
    wire stop_done = (state == FSPRX_STOP) & bit_end;

    fsprx_char_t rx_char;
    assign rx_char.data = rx_data;
    assign rx_char.perr = rx_perr;
    assign rx_char.ferr = ~rx;

    always_ff @(posedge CLK) begin
        if (RESET | ~run) begin
            state <= FSPRX_IDLE;
            ovs <= 4'h0;
            bitn <= 3'h0;
            shreg <= 8'h00;
            par_bit <= 1'b0;
            rx_prev <= 1'b1;
        end else if (tick) begin
            rx_prev <= rx;
            ovs <= ovs + 4'h1;
            unique case (state)
                FSPRX_IDLE: begin
                    ovs <= 4'h0;
                    if (rx_prev & ~rx) begin
                        state <= FSPRX_START;
                    end
                end
                FSPRX_START: begin
                    if (ovs == `FSPRX_MID_LAST) begin
                        ovs <= 4'h0;
                        bitn <= 3'h0;
                        // Glitch shorter than half a bit is dropped
                        state <= rx ? FSPRX_IDLE : FSPRX_DATA;
                    end
                end
                FSPRX_DATA: begin
                    if (ovs == `FSPRX_OVS_LAST) begin
                        shreg <= {rx, shreg[7:1]};
                        bitn <= bitn + 3'h1;
                        if (bitn == bits_last) begin
                            state <= par_en ? FSPRX_PARITY : FSPRX_STOP;
                        end
                    end
                end
                FSPRX_PARITY: begin
                    if (ovs == `FSPRX_OVS_LAST) begin
                        par_bit <= rx;
                        state <= FSPRX_STOP;
                    end
                end
                FSPRX_STOP: begin
                    // Only the first stop bit is checked; a second one reads as idle
                    if (ovs == `FSPRX_OVS_LAST) begin
                        state <= FSPRX_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Receive FIFO
    fsprx_char_t head;
    logic fifo_full;
    logic fifo_empty;
    logic [4:0] fifo_count;

    logic rd_live;

    wire rd_data = access & ~PWRITE & hit_data & rd_live;

    fsprx_fifo u_fifo (
        .clk(CLK),
        .reset(RESET),
        .push(stop_done),
        .wdata(rx_char),
        .pop(rd_data),
        .rdata(head),
        .full(fifo_full),
        .empty(fifo_empty),
        .count(fifo_count)
    );

    // ==========================================================
    // Status flags: hardware set wins over a software clear
    logic [4:0] flag_set;
    assign flag_set[`FSPRX_FLAG_ORER] = stop_done & fifo_full;
    assign flag_set[`FSPRX_FLAG_FER] = stop_done & ~rx;
    assign flag_set[`FSPRX_FLAG_PER] = stop_done & rx_perr;
    assign flag_set[`FSPRX_FLAG_BRK] = stop_done & rx_brk;
    assign flag_set[`FSPRX_FLAG_RDF] = (fifo_count >= `FSPRX_RDF_TRIG);

    wire wr_flags = wr & hit_flags;
    wire [4:0] clr_bits = (PWDATA[15:0] == 16'h0000) ? 5'h1f : PWDATA[4:0];
    wire [4:0] flag_clr = wr_flags ? clr_bits : 5'h00;
    wire [4:0] next_flags = (serial_flags & ~flag_clr) | flag_set;

    // All requests, error and break included, need the receive interrupt enable
    assign IRQ = receive_irq_enable & |(serial_flags & irq_mask);

    // ==========================================================
    // Register writes
    always_ff @(posedge CLK) begin
        if (RESET) begin
            serial_frame_mode <= `FSPRX_MODE_RST;
            baud_divisor <= `FSPRX_BAUD_RST;
            serial_control <= `FSPRX_CTRL_RST;
            serial_flags <= `FSPRX_FLAGS_RST;
            irq_mask <= `FSPRX_MASK_RST;
            standby_control_four <= `FSPRX_STBY_RST;
        end else begin
            serial_flags <= next_flags;
            if (wr & hit_mode) begin
                serial_frame_mode <= PWDATA[15:0];
            end
            if (wr & hit_baud) begin
                baud_divisor <= PWDATA[7:0];
            end
            if (wr & hit_ctrl) begin
                serial_control <= PWDATA[15:0];
            end
            if (wr & hit_mask) begin
                irq_mask <= PWDATA[4:0];
            end
            if (wr & hit_stby) begin
                standby_control_four <= PWDATA[7:0];
            end
        end
    end

    // ==========================================================
    // Read data, captured in the setup cycle
    wire [31:0] flags_word = {19'h0, fifo_count, 3'h0, serial_flags};
    wire [31:0] data_word = fifo_empty ? 32'h0 :
        {22'h0, head.perr, head.ferr, head.data};
    wire [31:0] next_prdata =
        hit_mode ? {16'h0, serial_frame_mode} :
        hit_baud ? {24'h0, baud_divisor} :
        hit_ctrl ? {16'h0, serial_control} :
        hit_flags ? flags_word :
        hit_data ? data_word :
        hit_mask ? {27'h0, irq_mask} :
        hit_stby ? {24'h0, standby_control_four} : 32'h0;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
            rd_live <= 1'b0;
        end else if (setup) begin
            PRDATA <= next_prdata;
            PSLVERR <= ~hit_any;
            // Pop only a character that was shown, so a push during setup is not lost
            rd_live <= ~fifo_empty;
        end
    end
endmodule

// file: fsprx_top_properties.sv
// Concurrent checks on the serial receiver's ports
`timescale 1ns/1ps
`include "fsprx_defines.svh"
module fsprx_top_checker (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ
);
    wire logic setup = PSEL && !PENABLE;
    wire logic acc = PSEL && PENABLE;
    wire logic acc_wr = acc && PWRITE;
    wire logic mapped = PADDR inside {`FSPRX_ADDR_MODE, `FSPRX_ADDR_BAUD, `FSPRX_ADDR_CTRL,
        `FSPRX_ADDR_FLAGS, `FSPRX_ADDR_DATA, `FSPRX_ADDR_MASK, `FSPRX_ADDR_STBY};
    logic rie_q;

    // ==========================================================
    // Shadow of the interrupt enable, so IRQ can be tied to it
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rie_q <= 1'b0;
        end else if (acc_wr && PADDR == `FSPRX_ADDR_CTRL) begin
            rie_q <= PWDATA[`FSPRX_CTRL_RIE];
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // ==========================================================
    // Bus and interrupt properties
    chk_ready_high: assert property (PREADY)
        else $error("Ready low");
    chk_unmapped_err: assert property (setup && !mapped |=> PSLVERR && PRDATA == 32'h0)
        else $error("Unmapped access not refused");
    chk_mapped_ok: assert property (setup && mapped |=> !PSLVERR)
        else $error("Mapped access refused");
    chk_read_stands: assert property (!setup |=> $stable({PRDATA, PSLVERR}))
        else $error("Read data moved outside setup");
    chk_narrow_upper: assert property (setup && !PWRITE && mapped |=> PRDATA[31:16] == 16'h0)
        else $error("Upper read bits not zero");
    chk_irq_off: assert property (
        acc_wr && PADDR == `FSPRX_ADDR_CTRL && !PWDATA[`FSPRX_CTRL_RIE] |=> !IRQ [*2])
        else $error("Interrupt with enable cleared");
    chk_irq_needs_enable: assert property (IRQ |-> rie_q)
        else $error("Interrupt without enable");
    chk_irq_sticky: assert property (IRQ && !acc |=> IRQ)
        else $error("Interrupt dropped without access");
    chk_mask_all: assert property (
        acc_wr && PADDR == `FSPRX_ADDR_MASK && PWDATA[4:0] == 5'h00 |=> !IRQ [*2])
        else $error("Interrupt with all sources masked");
endmodule

bind fsprx_top fsprx_top_checker fsprx_top_checker_inst (.CLK, .RESET, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ);

// file: fsprx_tx_model.sv
// Remote transmitter driving the serial receive line
`timescale 1ns/1ps
module fsprx_tx_model (
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;

    // Bits last whole clock cycles; the rounding drift over a frame is far below half a bit
    task automatic hold(input int cyc);
        repeat (cyc) @(posedge clk);
    endtask

    // Start bit, nb bits of v LSB first (parity included), stop bit, one idle bit
    task automatic send(input logic [8:0] v, input int nb, input logic stop, input int cyc);
        @(posedge clk);
        line <= 1'b0;
        hold(cyc);
        for (int i = 0; i < nb; i++) begin
            line <= v[i];
            hold(cyc);
        end
        line <= stop;
        hold(cyc);
        line <= 1'b1;
        hold(cyc);
    endtask

    // Low pulse shorter than half a bit, which must not start a character
    task automatic glitch(input int cyc);
        @(posedge clk);
        line <= 1'b0;
        hold(cyc);
        line <= 1'b1;
    endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the serial receiver
`timescale 1ns/1ps
`include "fsprx_defines.svh"
module tb_top;
    localparam logic [31:0] a_md = `FSPRX_ADDR_MODE;
    localparam logic [31:0] a_ct = `FSPRX_ADDR_CTRL;
    localparam logic [31:0] a_fl = `FSPRX_ADDR_FLAGS;
    localparam logic [31:0] a_dt = `FSPRX_ADDR_DATA;
    localparam logic [31:0] a_mk = `FSPRX_ADDR_MASK;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [31:0] paddr, pwdata, prdata, r;
    wire logic rx_line;
    localparam int sck_half = 5;
    logic [15:0] seed = 16'h2f28;
    logic [7:0] b;
    logic [7:0] q[$];
    logic sck = 1'b0;
    int sck_div = 0;
    int bt;
    int mismatches = 0;
    int checks_done = 0;

    fsprx_top fsprx_top_inst (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SERIAL_RX_LINE(rx_line), .SCK_IN(sck), .IRQ(irq));
    fsprx_tx_model fsprx_tx_model_inst (.clk(clk), .line(rx_line));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Free-running 16x clock for the external clock mode, one period every ten cycles
    always @(posedge clk) begin
        sck_div <= (sck_div == sck_half - 1) ? 0 : sck_div + 1;
        if (sck_div == sck_half - 1) begin
            sck <= ~sck;
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Divisor n, prescale p: sixteen ticks a bit, each (n+1)*p periods of 76.8 MHz;
    // divisor 124 gives 38400 bit/s, 5208 cycles a bit
    function automatic int bit_cyc(input int n, input int p);
        return 2000 * (n + 1) * p / 48;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // Bus master, bounded wait on ready
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            mismatches++;
            test_done();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, r, exp);
    endtask

    task automatic ci(input logic exp);
        @(negedge clk);
        check("irq", {31'h0, irq}, {31'h0, exp});
    endtask

    task automatic rx(input logic [7:0] v, input logic stop);
        fsprx_tx_model_inst.send({1'b0, v}, 8, stop, bt);
        repeat (8) @(posedge clk);
    endtask

    task automatic rxn(input logic [8:0] v, input int nb);
        fsprx_tx_model_inst.send(v, nb, 1'b1, bt);
        repeat (8) @(posedge clk);
    endtask

    task automatic setup(input logic [31:0] md, input logic [31:0] div, input logic [31:0] ct);
        wr(a_ct, 32'h0);
        wr(a_md, md);
        wr(`FSPRX_ADDR_BAUD, div);
        wr(a_fl, 32'h0);
        wr(a_ct, ct);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        ci(1'b0);
        rchk("mode", a_md, 32'h0);
        rchk("baud", `FSPRX_ADDR_BAUD, 32'hff);
        rchk("ctrl", a_ct, 32'h0);
        rchk("flags", a_fl, 32'h0);
        rchk("mask", a_mk, 32'h1f);
        rchk("stby", `FSPRX_ADDR_STBY, 32'hff);
        rchk("unmapped", 32'hfffe980c, 32'h0);
        check("slverr", {31'h0, e}, 32'h1);
        bt = bit_cyc(1, 1);
        setup(32'h0, 32'h1, 32'h50);
        rx(8'h5a, 1'b1);
        rchk("stopped", a_fl, 32'h0);
        wr(`FSPRX_ADDR_STBY, 32'hef);
        for (int i = 0; i < 17; i++) begin
            seed = lfsr(seed);
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
            if (i < 16) q.push_back(b);
            rx(b, 1'b1);
            if (i == 7) begin
                rchk("half", a_fl, 32'h0810);
                ci(1'b1);
            end
        end
        rchk("full", a_fl, 32'h1011);
        for (int i = 0; i < 16; i++) begin
            rchk("data", a_dt, {24'h0, q.pop_front()});
        end
        rchk("drained", a_fl, 32'h0011);
        rchk("empty", a_dt, 32'h0);
        wr(a_fl, 32'h0);
        rchk("cleared", a_fl, 32'h0);
        ci(1'b0);
        fsprx_tx_model_inst.glitch(bt / 4);
        repeat (900) @(posedge clk);
        rchk("glitch", a_fl, 32'h0);
        rx(8'h55, 1'b0);
        rchk("framing", a_fl, 32'h0102);
        ci(1'b1);
        wr(a_mk, 32'h0);
        ci(1'b0);
        wr(a_mk, 32'h1f);
        ci(1'b1);
        wr(a_ct, 32'h10);
        ci(1'b0);
        rchk("ferr data", a_dt, 32'h155);
        wr(a_fl, 32'h0);
        wr(a_ct, 32'h50);
        rx(8'h00, 1'b0);
        apb(1'b0, a_fl, 32'h0);
        check("break", r & 32'hf, 32'ha);
        rchk("break data", a_dt, 32'h100);
        wr(a_fl, 32'h0);
        wr(a_ct, 32'h40);
        rx(8'h3c, 1'b1);
        rchk("re off", a_fl, 32'h0);
        wr(a_ct, 32'h50);
        wr(a_md, 32'h80);
        rx(8'hc3, 1'b1);
        rchk("sync", a_fl, 32'h0);
        bt = bit_cyc(1, 4);
        setup(32'h21, 32'h1, 32'h50);
        seed = lfsr(seed);
        b = seed[7:0];
        rxn({^b, b}, 9);
        rxn({~^b, b}, 9);
        rchk("parity", a_fl, 32'h0204);
        rchk("par ok", a_dt, {24'h0, b});
        rchk("par bad", a_dt, {22'h0, 2'h2, b});
        bt = bit_cyc(1, 1);
        setup(32'h78, 32'h1, 32'h50);
        rxn({1'b0, ~^b[6:0], b[6:0]}, 8);
        rchk("seven", a_dt, {25'h0, b[6:0]});
        bt = 32 * sck_half;
        setup(32'h0, 32'h1, 32'h52);
        rx(8'h96, 1'b1);
        rchk("ext clock", a_dt, 32'h96);
        bt = bit_cyc(124, 1);
        setup(32'h0, 32'h7c, 32'h50);
        rx(8'ha7, 1'b1);
        rchk("rate", a_dt, 32'ha7);
        test_done();
    end

    initial begin
        #490000;
        mismatches++;
        test_done();
    end
endmodule
